// [logic/gpio_port_consts.svh]
/*
 Constants for the parallel I/O port: register offsets of both register
 groups, reset values and widths.
 Assumes it is included by the package and the design modules by bare name.
*/
`ifndef GPIO_PORT_CONSTS_SVH
`define GPIO_PORT_CONSTS_SVH

// Bus and port widths
`define IO_DW 32
`define IO_AW 5
`define IO_BE 4
`define IO_CW 4
// Port bits served by one byte lane
`define IO_LW 8

// Legacy register group, byte offsets
`define LEG_PIN 5'h00
`define LEG_SET 5'h04
`define LEG_DIR 5'h08
`define LEG_CLR 5'h0c
`define LEG_FUNC 5'h10

// Accelerated register group, byte offsets
`define FST_DIR 5'h00
`define FST_MASK 5'h10
`define FST_PIN 5'h14
`define FST_SET 5'h18
`define FST_CLR 5'h1c

// Reset values
`define RST_DIR 32'h0000_0000
`define RST_LATCH 32'h0000_0000
`define RST_FUNC 32'h0000_0000
`define RST_MASK 32'h0000_0000
`define RST_DATA 32'h0000_0000

// Extra wait cycles of a legacy access before its answer
`define LEG_WAIT_DEF 4'h5
// Cycles a legacy answer adds on top of its wait count
`define LEG_ANS_OFS 2
`define CNT_ZERO 4'h0
`define CNT_ONE 4'h1

`endif

// [logic/gpio_port_pkg.sv]
/*
 Types shared by the parallel I/O port: bus request and answer carriers,
 access state enums and the state records of both modules.
 Assumes the constants header sits beside it.
*/
`include "gpio_port_consts.svh"

package gpio_port_pkg;

  // Avalon-MM request from the master
  typedef struct packed {
    logic read;
    logic write;
    logic [`IO_AW-1:0] address;
    logic [`IO_BE-1:0] byteenable;
    logic [`IO_DW-1:0] writedata;
  } bus_req_s;

  // Avalon-MM answer to the master
  typedef struct packed {
    logic waitrequest;
    logic [`IO_DW-1:0] readdata;
  } bus_rsp_s;

  typedef enum logic [1:0] {LG_IDLE, LG_WAIT, LG_ACK} legacy_e;
  typedef enum logic {FS_IDLE, FS_ACK} fast_e;

  // Register state of the port
  typedef struct packed {
    logic [`IO_DW-1:0] dir;
    logic [`IO_DW-1:0] latch;
    logic [`IO_DW-1:0] funcSel;
    logic [`IO_DW-1:0] mask;
    legacy_e legSt;
    logic [`IO_CW-1:0] legCnt;
    bus_rsp_s legRsp;
    fast_e fstSt;
    bus_rsp_s fstRsp;
  } io_state_s;

  // Pad side state of the pin multiplexer
  typedef struct packed {
    logic [`IO_DW-1:0] pinOut;
    logic [`IO_DW-1:0] pinOe;
    logic [`IO_DW-1:0] pinLevel;
    logic [`IO_DW-1:0] periphIn;
  } mux_state_s;

endpackage

// [logic/pin_mux.sv]
/*
 Pin multiplexer: per pin, hands the pad to the port logic or to a
 peripheral, and samples the pad level.
 Assumes pad inputs synchronous to clk; all outputs are registered.
*/
`include "gpio_port_consts.svh"

module pin_mux (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [`IO_DW-1:0] funcSel,
  input wire logic [`IO_DW-1:0] gpioOut,
  input wire logic [`IO_DW-1:0] gpioOe,
  input wire logic [`IO_DW-1:0] periphOut,
  input wire logic [`IO_DW-1:0] periphOe,
  input wire logic [`IO_DW-1:0] pinIn,
  output logic [`IO_DW-1:0] pinOut,
  output logic [`IO_DW-1:0] pinOe,
  output logic [`IO_DW-1:0] pinLevel,
  output logic [`IO_DW-1:0] periphIn
);

  gpio_port_pkg::mux_state_s s;
  gpio_port_pkg::mux_state_s next_s;
  logic [`IO_DW-1:0] muxOut;
  logic [`IO_DW-1:0] muxOe;

  //////////////////////////////////////////////////////////////////////////
  // Per pin source selection
  genvar i;
  generate
    for (i = 0; i < `IO_DW; i++) begin : g_pin
      assign muxOut[i] = funcSel[i] ? periphOut[i] : gpioOut[i];
      assign muxOe[i] = funcSel[i] ? periphOe[i] : gpioOe[i];
    end
  endgenerate

  // Next pad state
  always_comb begin
    next_s = s;
    next_s.pinOut = muxOut;
    next_s.pinOe = muxOe;
    next_s.pinLevel = pinIn;
    next_s.periphIn = pinIn;
  end

  // Pads start undriven
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s.pinOut <= `RST_DATA;
      s.pinOe <= `RST_DIR;
      s.pinLevel <= `RST_DATA;
      s.periphIn <= `RST_DATA;
    end else begin
      s <= next_s;
    end
  end

  assign pinOut = s.pinOut;
  assign pinOe = s.pinOe;
  assign pinLevel = s.pinLevel;
  assign periphIn = s.periphIn;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  property p_gpio_owns_pin;
    @(posedge clk) disable iff (!rst_n)
    rst_n ##1 rst_n |-> ((pinOe & ~$past(funcSel))
      == ($past(gpioOe) & ~$past(funcSel)));
  endproperty
  a_gpio_owns_pin: assert property (p_gpio_owns_pin)
    else $error("unassigned pin not under port control");

  property p_periph_owns_pin;
    @(posedge clk) disable iff (!rst_n)
    rst_n ##1 rst_n |-> ((pinOut & $past(funcSel))
      == ($past(periphOut) & $past(funcSel)));
  endproperty
  a_periph_owns_pin: assert property (p_periph_owns_pin)
    else $error("assigned pin not driven by its peripheral");

endmodule

// [logic/parallel_io_port.sv]
/*
 Parallel I/O port with a legacy register group and an accelerated
 register group, each an Avalon-MM slave with waitrequest, both acting
 on one set of direction and output state.
 Assumes one clock, synchronous pad inputs, masters that hold a request
 until they sample waitrequest low.
*/
// What this block does
// - Unassigned pins follow the port registers
// - Multiplexer gives each pin one peripheral
// - Per-bit direction, changeable at any time
// - Set write raises ones, keeps others
// - Clear write lowers ones, keeps others
// - Output latch and pin level readable
// - Reset leaves every bit an input
// - Mask bits shield fast pin, set and clear writes
// - Byte lanes act on their own bits
// - Whole output value written at once
// - Legacy and fast groups reach the port
`include "gpio_port_consts.svh"

module parallel_io_port #(
  parameter logic [`IO_CW-1:0] LEGACY_WAIT = `LEG_WAIT_DEF
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire gpio_port_pkg::bus_req_s legReq,
  output gpio_port_pkg::bus_rsp_s legRsp,
  input wire gpio_port_pkg::bus_req_s fastReq,
  output gpio_port_pkg::bus_rsp_s fastRsp,
  input wire logic [`IO_DW-1:0] periphOut,
  input wire logic [`IO_DW-1:0] periphOe,
  output logic [`IO_DW-1:0] periphIn,
  input wire logic [`IO_DW-1:0] pinIn,
  output logic [`IO_DW-1:0] pinOut,
  output logic [`IO_DW-1:0] pinOe
);

  localparam gpio_port_pkg::io_state_s RST_STATE = '{
    dir: `RST_DIR,
    latch: `RST_LATCH,
    funcSel: `RST_FUNC,
    mask: `RST_MASK,
    legSt: gpio_port_pkg::LG_IDLE,
    legCnt: `CNT_ZERO,
    legRsp: '{waitrequest: 1'b1, readdata: `RST_DATA},
    fstSt: gpio_port_pkg::FS_IDLE,
    fstRsp: '{waitrequest: 1'b1, readdata: `RST_DATA}
  };

  gpio_port_pkg::io_state_s s;
  gpio_port_pkg::io_state_s next_s;
  logic [`IO_DW-1:0] pinLevel;
  logic [`IO_DW-1:0] legRead;
  logic [`IO_DW-1:0] fastRead;
  logic [`IO_DW-1:0] legLane;
  logic [`IO_DW-1:0] fastLane;
  logic [`IO_DW-1:0] fastBits;
  logic legWr;
  logic fastWr;

  // Byte enables widened to one bit per port bit
  function automatic logic [`IO_DW-1:0] lanes(input logic [`IO_BE-1:0] be);
    logic [`IO_DW-1:0] m;
    m = '0;
    for (int b = 0; b < `IO_BE; b++) begin
      m[b*`IO_LW +: `IO_LW] = {`IO_LW{be[b]}};
    end
    return m;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Decoded strobes and lane masks
  assign legWr = (s.legSt == gpio_port_pkg::LG_ACK) && legReq.write;
  assign fastWr = (s.fstSt == gpio_port_pkg::FS_ACK) && fastReq.write;
  assign legLane = lanes(legReq.byteenable);
  assign fastLane = lanes(fastReq.byteenable);
  assign fastBits = fastLane & ~s.mask;

  // Legacy readback
  always_comb begin
    unique case (legReq.address)
      `LEG_PIN: legRead = pinLevel;
      `LEG_SET: legRead = s.latch;
      `LEG_DIR: legRead = s.dir;
      `LEG_FUNC: legRead = s.funcSel;
      default: legRead = `RST_DATA;
    endcase
  end

  // Accelerated readback, masked bits read as zero on pin and set reads
  always_comb begin
    unique case (fastReq.address)
      `FST_DIR: fastRead = s.dir;
      `FST_MASK: fastRead = s.mask;
      `FST_PIN: fastRead = pinLevel & ~s.mask;
      `FST_SET: fastRead = s.latch & ~s.mask;
      default: fastRead = `RST_DATA;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Next state: handshakes, then legacy writes, then fast writes on top
  always_comb begin
    next_s = s;
    // Legacy slave: slower answer, counted wait cycles
    unique case (s.legSt)
      gpio_port_pkg::LG_IDLE: begin
        if (legReq.read || legReq.write) begin
          next_s.legSt = gpio_port_pkg::LG_WAIT;
          next_s.legCnt = LEGACY_WAIT;
        end
      end
      gpio_port_pkg::LG_WAIT: begin
        if (s.legCnt == `CNT_ZERO) begin
          next_s.legSt = gpio_port_pkg::LG_ACK;
          next_s.legRsp.waitrequest = 1'b0;
          next_s.legRsp.readdata = legRead;
        end else begin
          next_s.legCnt = s.legCnt - `CNT_ONE;
        end
      end
      gpio_port_pkg::LG_ACK: begin
        next_s.legSt = gpio_port_pkg::LG_IDLE;
        next_s.legRsp.waitrequest = 1'b1;
      end
      default: begin
        next_s.legSt = gpio_port_pkg::LG_IDLE;
        next_s.legRsp.waitrequest = 1'b1;
      end
    endcase
    // Fast slave: answer one cycle after the request
    unique case (s.fstSt)
      gpio_port_pkg::FS_IDLE: begin
        if (fastReq.read || fastReq.write) begin
          next_s.fstSt = gpio_port_pkg::FS_ACK;
          next_s.fstRsp.waitrequest = 1'b0;
          next_s.fstRsp.readdata = fastRead;
        end
      end
      gpio_port_pkg::FS_ACK: begin
        next_s.fstSt = gpio_port_pkg::FS_IDLE;
        next_s.fstRsp.waitrequest = 1'b1;
      end
    endcase
    // Legacy writes, applied first
    if (legWr) begin
      unique case (legReq.address)
        `LEG_SET: next_s.latch = s.latch
          | (legReq.writedata & legLane);
        `LEG_CLR: next_s.latch = s.latch
          & ~(legReq.writedata & legLane);
        `LEG_DIR: next_s.dir = (s.dir & ~legLane)
          | (legReq.writedata & legLane);
        `LEG_FUNC: next_s.funcSel = (s.funcSel & ~legLane)
          | (legReq.writedata & legLane);
        default: ;
      endcase
    end
    // Fast writes act on the legacy result, so they land last
    if (fastWr) begin
      unique case (fastReq.address)
        `FST_DIR: next_s.dir = (next_s.dir & ~fastLane)
          | (fastReq.writedata & fastLane);
        `FST_MASK: next_s.mask = (s.mask & ~fastLane)
          | (fastReq.writedata & fastLane);
        `FST_PIN: next_s.latch = (next_s.latch & ~fastBits)
          | (fastReq.writedata & fastBits);
        `FST_SET: next_s.latch = next_s.latch
          | (fastReq.writedata & fastBits);
        `FST_CLR: next_s.latch = next_s.latch
          & ~(fastReq.writedata & fastBits);
        default: ;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= RST_STATE;
    end else begin
      s <= next_s;
    end
  end

  assign legRsp = s.legRsp;
  assign fastRsp = s.fstRsp;

  //////////////////////////////////////////////////////////////////////////
  // Pad multiplexer
  pin_mux u_pin_mux (
    .clk(clk),
    .rst_n(rst_n),
    .funcSel(s.funcSel),
    .gpioOut(s.latch),
    .gpioOe(s.dir),
    .periphOut(periphOut),
    .periphOe(periphOe),
    .pinIn(pinIn),
    .pinOut(pinOut),
    .pinOe(pinOe),
    .pinLevel(pinLevel),
    .periphIn(periphIn)
  );

  //////////////////////////////////////////////////////////////////////////
  // Checks
  property p_reset_inputs;
    @(posedge clk) disable iff (!rst_n)
    $rose(rst_n) |-> (s.dir == `RST_DIR) && (pinOe == `RST_DIR);
  endproperty
  a_reset_inputs: assert property (p_reset_inputs)
    else $error("port not all inputs after reset");

  property p_dir_to_pad;
    @(posedge clk) disable iff (!rst_n)
    (fastWr && fastReq.address == `FST_DIR && !legWr)
      |=> ##1 ((pinOe & $past(fastLane, 2) & ~s.funcSel)
        == ($past(fastReq.writedata, 2) & $past(fastLane, 2)
          & ~s.funcSel));
  endproperty
  a_dir_to_pad: assert property (p_dir_to_pad)
    else $error("direction write did not reach the pad");

  property p_set_bits;
    @(posedge clk) disable iff (!rst_n)
    (fastWr && fastReq.address == `FST_SET)
      |=> ((s.latch & $past(fastReq.writedata & fastBits))
        == $past(fastReq.writedata & fastBits));
  endproperty
  a_set_bits: assert property (p_set_bits)
    else $error("set write left a selected bit low");

  property p_clear_keeps;
    @(posedge clk) disable iff (!rst_n)
    (legWr && legReq.address == `LEG_CLR && !fastWr)
      |=> (s.latch == $past(s.latch & ~(legReq.writedata & legLane)));
  endproperty
  a_clear_keeps: assert property (p_clear_keeps)
    else $error("clear write result wrong");

  property p_pin_read;
    @(posedge clk) disable iff (!rst_n)
    (s.fstSt == gpio_port_pkg::FS_IDLE && fastReq.read
      && fastReq.address == `FST_PIN)
      |=> !fastRsp.waitrequest
        && (fastRsp.readdata == $past(pinLevel & ~s.mask));
  endproperty
  a_pin_read: assert property (p_pin_read)
    else $error("pin level readback wrong");

  property p_mask_shields;
    @(posedge clk) disable iff (!rst_n)
    (fastWr && fastReq.address == `FST_PIN && !legWr)
      |=> ((s.latch & $past(s.mask)) == $past(s.latch & s.mask));
  endproperty
  a_mask_shields: assert property (p_mask_shields)
    else $error("masked bit changed by a fast write");

  property p_lane_only;
    @(posedge clk) disable iff (!rst_n)
    (fastWr && fastReq.address == `FST_DIR && !legWr)
      |=> ((s.dir & ~$past(fastLane)) == $past(s.dir & ~fastLane));
  endproperty
  a_lane_only: assert property (p_lane_only)
    else $error("disabled byte lane changed");

  property p_whole_value;
    @(posedge clk) disable iff (!rst_n)
    (fastWr && fastReq.address == `FST_PIN)
      |=> ((s.latch & $past(fastBits))
        == $past(fastReq.writedata & fastBits));
  endproperty
  a_whole_value: assert property (p_whole_value)
    else $error("whole port write not taken");

  property p_fast_answer;
    @(posedge clk) disable iff (!rst_n)
    (s.fstSt == gpio_port_pkg::FS_IDLE && (fastReq.read || fastReq.write))
      |=> !fastRsp.waitrequest ##1 fastRsp.waitrequest;
  endproperty
  a_fast_answer: assert property (p_fast_answer)
    else $error("fast access not answered in one cycle");

  property p_legacy_slower;
    @(posedge clk) disable iff (!rst_n)
    (s.legSt == gpio_port_pkg::LG_IDLE && (legReq.read || legReq.write))
      |=> legRsp.waitrequest [*2];
  endproperty
  a_legacy_slower: assert property (p_legacy_slower)
    else $error("legacy access answered too early");

  property p_order;
    @(posedge clk) disable iff (!rst_n)
    (legWr && legReq.address == `LEG_SET && fastWr
      && fastReq.address == `FST_CLR)
      |=> ((s.latch & $past(legReq.writedata & fastReq.writedata
        & legLane & fastBits)) == `RST_DATA);
  endproperty
  a_order: assert property (p_order)
    else $error("same-cycle accesses applied out of order");

  // Legacy answer time: fixed, so software can count on it
  localparam int LEG_LAT = LEGACY_WAIT + `LEG_ANS_OFS;

  property p_leg_answer;
    @(posedge clk) disable iff (!rst_n)
    (s.legSt == gpio_port_pkg::LG_IDLE && (legReq.read || legReq.write))
      |-> ##LEG_LAT !legRsp.waitrequest ##1 legRsp.waitrequest;
  endproperty
  a_leg_answer: assert property (p_leg_answer)
    else $error("legacy access not answered on time");

  property p_leg_set;
    @(posedge clk) disable iff (!rst_n)
    (legWr && legReq.address == `LEG_SET && !fastWr)
      |=> (s.latch == $past(s.latch | (legReq.writedata & legLane)));
  endproperty
  a_leg_set: assert property (p_leg_set)
    else $error("legacy set write result wrong");

  property p_leg_dir;
    @(posedge clk) disable iff (!rst_n)
    (legWr && legReq.address == `LEG_DIR && !fastWr)
      |=> (s.dir == $past((s.dir & ~legLane)
        | (legReq.writedata & legLane)));
  endproperty
  a_leg_dir: assert property (p_leg_dir)
    else $error("legacy direction write result wrong");

  // Read data is taken from the state at the edge that opens the answer
  property p_latch_read;
    @(posedge clk) disable iff (!rst_n)
    (s.legSt == gpio_port_pkg::LG_WAIT && s.legCnt == `CNT_ZERO
      && legReq.read && legReq.address == `LEG_SET)
      |=> !legRsp.waitrequest && (legRsp.readdata == $past(s.latch));
  endproperty
  a_latch_read: assert property (p_latch_read)
    else $error("output latch readback wrong");

endmodule

// [tb/pad_model.sv]
/*
 Outside circuitry at the port pads: drives its own level on every pad
 whose output driver is off, and sees the port's level elsewhere.
 Assumes the pad drive and enable from the port, and a level from the bench.
*/
`include "gpio_port_consts.svh"

module pad_model (
  input wire logic [`IO_DW-1:0] pinOut,
  input wire logic [`IO_DW-1:0] pinOe,
  input wire logic [`IO_DW-1:0] extDrive,
  output logic [`IO_DW-1:0] pinIn
);
  timeunit 1ns;
  timeprecision 1ps;

  // Pad level: port drive where enabled, outside drive elsewhere
  assign pinIn = (pinOe & pinOut) | (~pinOe & extDrive);
endmodule

// [tb/parallel_io_port_with_fast_access_tb.sv]
/*
 Self-checking bench of the parallel I/O port: both register groups,
 masks, byte lanes, pad levels and pin multiplexing.
 Assumes the package, the constants header and the pad model.
*/
`include "gpio_port_consts.svh"

module parallel_io_port_with_fast_access_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [`IO_CW-1:0] LW = 4'h3;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  gpio_port_pkg::bus_req_s legReq = '0;
  gpio_port_pkg::bus_req_s fastReq = '0;
  gpio_port_pkg::bus_rsp_s legRsp;
  gpio_port_pkg::bus_rsp_s fastRsp;
  logic [31:0] periphOut = '0;
  logic [31:0] periphOe = '0;
  logic [31:0] extDrive = '0;
  logic [31:0] periphIn;
  logic [31:0] pinIn;
  logic [31:0] pinOut;
  logic [31:0] pinOe;
  int num_errors = 0;
  int n_checks = 0;
  int lastN;

  ////////////////////////////////////////////////////////////////////////
  // Clock at 200 MHz
  always #2.5 clk = ~clk;

  parallel_io_port #(.LEGACY_WAIT(LW)) dut (
    .clk(clk), .rst_n(rst_n), .legReq(legReq), .legRsp(legRsp),
    .fastReq(fastReq), .fastRsp(fastRsp), .periphOut(periphOut),
    .periphOe(periphOe), .periphIn(periphIn), .pinIn(pinIn),
    .pinOut(pinOut), .pinOe(pinOe)
  );

  pad_model pads (
    .pinOut(pinOut), .pinOe(pinOe), .extDrive(extDrive), .pinIn(pinIn)
  );

  ////////////////////////////////////////////////////////////////////////
  // Compare one value and count it
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One Avalon-MM transfer; held until waitrequest is sampled low or 100 cycles pass
  task automatic xfer(input logic f, input logic w, input logic [4:0] a,
                      input logic [3:0] be, input logic [31:0] d,
                      output logic [31:0] q);
    gpio_port_pkg::bus_req_s r;
    logic wreq;
    r.read = !w;
    r.write = w;
    r.address = a;
    r.byteenable = be;
    r.writedata = d;
    @(posedge clk);
    if (f) fastReq <= r;
    else legReq <= r;
    lastN = 0;
    do begin
      @(posedge clk);
      lastN++;
      wreq = f ? fastRsp.waitrequest : legRsp.waitrequest;
    end while (wreq !== 1'b0 && lastN < 100);
    q = f ? fastRsp.readdata : legRsp.readdata;
    if (f) fastReq <= '0;
    else legReq <= '0;
    chk("bus answer", 1'b0, wreq);
  endtask

  task automatic wr(input logic f, input logic [4:0] a, input logic [31:0] d,
                    input logic [3:0] be = 4'hf);
    logic [31:0] q;
    xfer(f, 1'b1, a, be, d, q);
  endtask

  task automatic rd(input logic f, input logic [4:0] a,
                    input logic [31:0] e, input string nm);
    logic [31:0] q;
    xfer(f, 1'b0, a, 4'hf, 32'h0, q);
    chk(nm, e, q);
  endtask

  // Let a register change reach the pads and the pad sampler
  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Reset state
  task automatic t_reset();
    chk("pinOe", 32'h0, pinOe);
    rd(1'b0, `LEG_DIR, 32'h0, "leg dir");
    rd(1'b0, `LEG_FUNC, 32'h0, "func");
    rd(1'b1, `FST_MASK, 32'h0, "mask");
  endtask

  // Direction and readback through both groups, set and clear through the legacy group
  task automatic t_setclr();
    extDrive <= 32'ha5a5_0000;
    wr(1'b0, `LEG_DIR, 32'h0000_ffff);
    wr(1'b0, `LEG_SET, 32'h0000_00f0);
    wr(1'b0, `LEG_SET, 32'h0000_000f);
    wr(1'b0, `LEG_CLR, 32'h0000_0030);
    rd(1'b0, `LEG_SET, 32'h0000_00cf, "latch");
    rd(1'b0, `LEG_CLR, 32'h0, "clr read");
    settle();
    chk("pinOe", 32'h0000_ffff, pinOe);
    chk("pinOut", 32'h0000_00cf, pinOut & pinOe);
    rd(1'b0, `LEG_PIN, 32'ha5a5_00cf, "pins");
    rd(1'b1, `FST_DIR, 32'h0000_ffff, "fast dir");
    wr(1'b1, `FST_DIR, 32'hffff_0000);
    rd(1'b0, `LEG_DIR, 32'hffff_0000, "leg dir");
    settle();
    chk("pinOe", 32'hffff_0000, pinOe);
  endtask

  // Masked group writes, whole-port writes and byte lanes
  task automatic t_fast();
    wr(1'b1, `FST_DIR, 32'h0000_ffff, 4'b0011);
    rd(1'b0, `LEG_DIR, 32'hffff_ffff, "lane dir");
    wr(1'b1, `FST_PIN, 32'h1234_5678);
    settle();
    chk("pinOut", 32'h1234_5678, pinOut);
    wr(1'b1, `FST_MASK, 32'h0000_ff00);
    wr(1'b1, `FST_PIN, 32'hffff_ffff);
    rd(1'b0, `LEG_SET, 32'hffff_56ff, "latch");
    rd(1'b1, `FST_SET, 32'hffff_00ff, "fast set");
    settle();
    rd(1'b1, `FST_PIN, 32'hffff_00ff, "fast pin");
    wr(1'b1, `FST_CLR, 32'hffff_ffff);
    rd(1'b0, `LEG_SET, 32'h0000_5600, "latch");
    wr(1'b1, `FST_MASK, 32'h0);
    wr(1'b1, `FST_PIN, 32'haaaa_aaaa, 4'b0100);
    wr(1'b0, `LEG_SET, 32'h0000_00ff, 4'b0001);
    wr(1'b1, `FST_SET, 32'hffff_ffff, 4'b1000);
    wr(1'b1, `FST_CLR, 32'hffff_ffff, 4'b0010);
    rd(1'b0, `LEG_SET, 32'hffaa_00ff, "latch");
  endtask

  // Unmapped places and answer times of both groups
  task automatic t_misc();
    rd(1'b0, 5'h14, 32'h0, "leg hole");
    wr(1'b0, 5'h18, 32'hffff_ffff);
    rd(1'b0, `LEG_SET, 32'hffaa_00ff, "latch");
    chk("leg cycles", LW + 3, lastN);
    rd(1'b1, 5'h04, 32'h0, "fast hole");
    chk("fast cycles", 32'h2, lastN);
  endtask

  // Pins handed to a peripheral and back
  task automatic t_mux();
    wr(1'b0, `LEG_FUNC, 32'h0000_00ff);
    periphOut <= 32'h0000_0055;
    periphOe <= 32'h0000_00ff;
    settle();
    chk("pinOut", 32'hffaa_0055, pinOut);
    chk("periphIn", 32'hffaa_0055, periphIn);
    wr(1'b0, `LEG_FUNC, 32'h0);
    settle();
    chk("pinOut", 32'hffaa_00ff, pinOut);
  endtask

  // Legacy set and fast clear on one edge: fast lands on top
  task automatic t_order();
    fork
      wr(1'b0, `LEG_SET, 32'h0000_ff00);
      begin
        repeat (LW + 1) @(posedge clk);
        wr(1'b1, `FST_CLR, 32'h0000_0f00);
      end
    join
    rd(1'b0, `LEG_SET, 32'hffaa_f0ff, "order");
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_setclr();
    t_fast();
    t_misc();
    t_mux();
    t_order();
    complete_run();
  end

  // Watchdog against a hung handshake
  initial begin
    #50000;
    num_errors++;
    complete_run();
  end
endmodule
